// ==== rtl/nvsr_host.sv ====
`timescale 1ns/1ps
`include "nvsr_map.svh"
module nvsr_host #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 16,
   parameter int STORE_START_DELAY_NS = `NVSR_STORE_START_DELAY_NS,
   parameter int POST_BUSY_HOLDOFF_NS = `NVSR_POST_BUSY_HOLDOFF_NS,
   parameter int POWERUP_RECALL_NS = `NVSR_POWERUP_RECALL_NS,
   parameter int STORE_CYCLE_NS = `NVSR_STORE_CYCLE_NS,
   parameter int RECALL_CYCLE_NS = `NVSR_RECALL_CYCLE_NS,
   parameter int ACCESS_NS = `NVSR_ACCESS_NS
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // command port
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic o_cmd_ready,
   output logic o_rsp_valid,
   output logic [DATA_W-1:0] o_rdata,
   // status
   output logic o_dirty,
   output logic o_power_loss_store_en,
   input wire logic i_supply_low,
   // memory pins
   output logic [ADDR_W-1:0] o_addr,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic o_upper_byte_enable_n,
   output logic o_lower_byte_enable_n,
   input wire logic [DATA_W-1:0] i_dq,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   // busy/request open-drain pin
   input wire logic i_store_busy_request_n,
   output logic o_store_busy_request_n,
   output logic o_store_busy_request_n_oe
);
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + `NVSR_CLK_PERIOD_NS - 1) / `NVSR_CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc

   function automatic logic [15:0] seq_addr(input logic [2:0] idx, input nvsr_pkg::nvsr_cmd_t cmd);
      logic [15:0] a;
      a = `NVSR_SEQ_ADDR0;
      case (idx)
         3'h0: a = `NVSR_SEQ_ADDR0;
         3'h1: a = `NVSR_SEQ_ADDR1;
         3'h2: a = `NVSR_SEQ_ADDR2;
         3'h3: a = `NVSR_SEQ_ADDR3;
         3'h4: a = `NVSR_SEQ_ADDR4;
         default: begin
            case (cmd)
               nvsr_pkg::CMD_SW_RECALL: a = `NVSR_SEQ_RECALL;
               nvsr_pkg::CMD_PLS_OFF: a = `NVSR_SEQ_PLS_OFF;
               nvsr_pkg::CMD_PLS_ON: a = `NVSR_SEQ_PLS_ON;
               default: a = `NVSR_SEQ_STORE;
            endcase
         end
      endcase
      return a;
   endfunction : seq_addr

   localparam logic [31:0] START_CYC = 32'(ns_to_cyc(STORE_START_DELAY_NS));
   localparam logic [31:0] HOLDOFF_CYC = 32'(ns_to_cyc(POST_BUSY_HOLDOFF_NS));
   localparam logic [31:0] BOOT_CYC = 32'(ns_to_cyc(POWERUP_RECALL_NS));
   localparam logic [31:0] STORE_CYC = 32'(ns_to_cyc(STORE_CYCLE_NS));
   localparam logic [31:0] RECALL_CYC = 32'(ns_to_cyc(RECALL_CYCLE_NS));
   localparam logic [31:0] ACC_CYC = 32'(ns_to_cyc(ACCESS_NS));

   nvsr_pkg::nvsr_state_t state_q;
   nvsr_pkg::nvsr_cmd_t cmd_q;
   logic [31:0] timer_q;
   logic [2:0] idx_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic busy_s;
   logic supply_low_s;
   logic single_q;
   logic pull_q;
   logic timer_done;

   nvsr_sync #(.RST_VAL(1'b1)) u_busy_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_store_busy_request_n),
      .o_sync(busy_s)
   );

   nvsr_sync #(.RST_VAL(1'b1)) u_supply_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_supply_low),
      .o_sync(supply_low_s)
   );

   assign timer_done = (timer_q == 32'h0000_0001);
   // no new request while supply is low
   assign o_cmd_ready = (state_q == nvsr_pkg::ST_IDLE) && !supply_low_s;
   assign o_store_busy_request_n = 1'b0;
   assign o_store_busy_request_n_oe = pull_q;
   assign o_upper_byte_enable_n = 1'b0;
   assign o_lower_byte_enable_n = 1'b0;

   // main sequencer
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= nvsr_pkg::ST_BOOT;
         timer_q <= 32'h0000_0000;
         cmd_q <= nvsr_pkg::CMD_READ;
         idx_q <= 3'h0;
         single_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         case (state_q)
            nvsr_pkg::ST_BOOT: begin
               // wait out the power-up recall, then for busy high
               if (timer_q == 32'h0000_0000) begin
                  timer_q <= BOOT_CYC;
               end else if (timer_done) begin
                  state_q <= nvsr_pkg::ST_WAIT_HIGH;
               end else begin
                  timer_q <= timer_q - 32'h0000_0001;
               end
            end
            nvsr_pkg::ST_IDLE: begin
               if (i_cmd_valid && o_cmd_ready) begin
                  cmd_q <= nvsr_pkg::nvsr_cmd_t'(i_cmd);
                  addr_q <= i_addr;
                  wdata_q <= i_wdata;
                  idx_q <= 3'h0;
                  single_q <= (i_cmd == nvsr_pkg::CMD_READ) || (i_cmd == nvsr_pkg::CMD_WRITE);
                  if (i_cmd == nvsr_pkg::CMD_HW_STORE) begin
                     timer_q <= START_CYC;
                     state_q <= nvsr_pkg::ST_HW_PULL;
                  end else begin
                     timer_q <= ACC_CYC;
                     state_q <= nvsr_pkg::ST_ACCESS;
                  end
               end
            end
            nvsr_pkg::ST_ACCESS: begin
               if (timer_done) begin
                  state_q <= nvsr_pkg::ST_RECOVER;
               end else begin
                  timer_q <= timer_q - 32'h0000_0001;
               end
            end
            nvsr_pkg::ST_RECOVER: begin
               // each sequence read is followed by one ST_RECOVER cycle, chip enable high, before the next
               if (single_q) begin
                  state_q <= nvsr_pkg::ST_IDLE;
               end else if (idx_q != `NVSR_SEQ_LAST) begin
                  idx_q <= idx_q + 3'h1;
                  timer_q <= ACC_CYC;
                  state_q <= nvsr_pkg::ST_ACCESS;
               end else if (cmd_q == nvsr_pkg::CMD_PLS_OFF || cmd_q == nvsr_pkg::CMD_PLS_ON) begin
                  // make the new setting persistent
                  cmd_q <= nvsr_pkg::CMD_SW_STORE;
                  idx_q <= 3'h0;
                  timer_q <= ACC_CYC;
                  state_q <= nvsr_pkg::ST_ACCESS;
               end else begin
                  timer_q <= (cmd_q == nvsr_pkg::CMD_SW_RECALL) ? RECALL_CYC : STORE_CYC;
                  state_q <= nvsr_pkg::ST_NV_WAIT;
               end
            end
            nvsr_pkg::ST_HW_PULL: begin
               // release after the start delay so an idle request ends
               if (timer_done) begin
                  timer_q <= o_dirty ? STORE_CYC : 32'h0000_0002;
                  state_q <= nvsr_pkg::ST_NV_WAIT;
               end else begin
                  timer_q <= timer_q - 32'h0000_0001;
               end
            end
            nvsr_pkg::ST_NV_WAIT: begin
               if (timer_done) begin
                  state_q <= nvsr_pkg::ST_WAIT_HIGH;
               end else begin
                  timer_q <= timer_q - 32'h0000_0001;
               end
            end
            nvsr_pkg::ST_WAIT_HIGH: begin
               if (busy_s) begin
                  timer_q <= HOLDOFF_CYC;
                  state_q <= nvsr_pkg::ST_HOLDOFF;
               end
            end
            nvsr_pkg::ST_HOLDOFF: begin
               if (timer_done) begin
                  state_q <= nvsr_pkg::ST_IDLE;
               end else begin
                  timer_q <= timer_q - 32'h0000_0001;
               end
            end
            default: begin
               state_q <= nvsr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // memory pin drive, only inside an access window
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_addr <= '0;
         o_dq <= '0;
         o_dq_oe <= 1'b0;
      end else begin
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_dq_oe <= 1'b0;
         if (state_q == nvsr_pkg::ST_ACCESS && !timer_done) begin
            o_ce_n <= 1'b0;
            if (single_q) begin
               o_addr <= addr_q;
               o_dq <= wdata_q;
               o_we_n <= !(cmd_q == nvsr_pkg::CMD_WRITE && busy_s);
               o_oe_n <= (cmd_q == nvsr_pkg::CMD_WRITE);
               o_dq_oe <= (cmd_q == nvsr_pkg::CMD_WRITE);
            end else begin
               // bits above 15 zero; device compares 14..2 only
               o_addr <= ADDR_W'(seq_addr(idx_q, cmd_q));
               o_oe_n <= 1'b0;
            end
         end
      end
   end

   // response and read data capture
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rsp_valid <= 1'b0;
         o_rdata <= '0;
      end else begin
         o_rsp_valid <= (state_q == nvsr_pkg::ST_RECOVER && single_q) ||
                        (state_q == nvsr_pkg::ST_HOLDOFF && timer_done && cmd_q != nvsr_pkg::CMD_READ);
         if (state_q == nvsr_pkg::ST_ACCESS && timer_done && single_q && cmd_q == nvsr_pkg::CMD_READ) begin
            o_rdata <= i_dq;
         end
      end
   end

   // busy/request pull
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pull_q <= 1'b0;
      end else begin
         pull_q <= (state_q == nvsr_pkg::ST_IDLE && i_cmd_valid && o_cmd_ready && i_cmd == nvsr_pkg::CMD_HW_STORE) ||
                   (state_q == nvsr_pkg::ST_HW_PULL && !timer_done);
      end
   end

   // write-since-store tracking and power-loss store setting
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_dirty <= 1'b0;
         o_power_loss_store_en <= `NVSR_PLS_EN_RST;
      end else begin
         if (!o_we_n && !o_ce_n) begin
            o_dirty <= 1'b1;
         end else if (state_q == nvsr_pkg::ST_NV_WAIT && timer_done) begin
            o_dirty <= 1'b0;
         end
         if (state_q == nvsr_pkg::ST_RECOVER && idx_q == `NVSR_SEQ_LAST && !single_q) begin
            if (cmd_q == nvsr_pkg::CMD_PLS_OFF) begin
               o_power_loss_store_en <= 1'b0;
            end else if (cmd_q == nvsr_pkg::CMD_PLS_ON) begin
               o_power_loss_store_en <= 1'b1;
            end
         end
      end
   end

   sequence s_seq_read;
      (state_q == nvsr_pkg::ST_ACCESS) && !single_q;
   endsequence

   property p_write_needs_busy_high;
      @(posedge i_sys_clk) disable iff (i_sys_rst) !o_we_n |-> !o_ce_n && $past(busy_s);
   endproperty
   a_write_needs_busy_high: assert property (p_write_needs_busy_high) else $error("write while busy low");

   property p_we_high_in_seq;
      @(posedge i_sys_clk) disable iff (i_sys_rst) s_seq_read |=> o_we_n;
   endproperty
   a_we_high_in_seq: assert property (p_we_high_in_seq) else $error("write enable low in sequence");

   property p_first_addr;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         s_seq_read and (idx_q == 3'h0) and !timer_done |=> o_addr[15:0] == 16'h4E38;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("wrong first sequence address");

   property p_holdoff_quiet;
      @(posedge i_sys_clk) disable iff (i_sys_rst) (state_q == nvsr_pkg::ST_HOLDOFF) |=> o_ce_n;
   endproperty
   a_holdoff_quiet: assert property (p_holdoff_quiet) else $error("access during holdoff");

   property p_boot_quiet;
      @(posedge i_sys_clk) disable iff (i_sys_rst) (state_q == nvsr_pkg::ST_BOOT) |=> o_ce_n && o_we_n;
   endproperty
   a_boot_quiet: assert property (p_boot_quiet) else $error("access during power-up recall");

   property p_pull_holds;
      @(posedge i_sys_clk) disable iff (i_sys_rst) $rose(pull_q) |-> pull_q [*2];
   endproperty
   a_pull_holds: assert property (p_pull_holds) else $error("request pulse too short");

   property p_busy_high_to_holdoff;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (state_q == nvsr_pkg::ST_WAIT_HIGH) && busy_s |=> (state_q == nvsr_pkg::ST_HOLDOFF) && !pull_q;
   endproperty
   a_busy_high_to_holdoff: assert property (p_busy_high_to_holdoff) else $error("holdoff not entered");

   property p_supply_low_refuses;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (state_q == nvsr_pkg::ST_IDLE) && supply_low_s |=> (state_q == nvsr_pkg::ST_IDLE);
   endproperty
   a_supply_low_refuses: assert property (p_supply_low_refuses) else $error("command taken at low supply");

   property p_pls_then_store;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (state_q == nvsr_pkg::ST_RECOVER) && !single_q && (idx_q == 3'h5) &&
         (cmd_q == nvsr_pkg::CMD_PLS_OFF || cmd_q == nvsr_pkg::CMD_PLS_ON)
         |=> (cmd_q == nvsr_pkg::CMD_SW_STORE) && (state_q == nvsr_pkg::ST_ACCESS);
   endproperty
   a_pls_then_store: assert property (p_pls_then_store) else $error("no store after setting change");
endmodule : nvsr_host

// ==== rtl/nvsr_map.svh ====
`ifndef NVSR_MAP_SVH
`define NVSR_MAP_SVH
// How it works
// - with no pending write, the requester itself must return busy/request high
// - a command is six reads; first five at 4E38, B1C7, 83E0, 7C1F, 703F
// - any other access inside the six reads aborts the command
// - write enable stays high throughout all six reads of a command
// - after changing the power-loss setting the host issues a store to keep it

// command sequence addresses
`define NVSR_SEQ_ADDR0 16'h4E38
`define NVSR_SEQ_ADDR1 16'hB1C7
`define NVSR_SEQ_ADDR2 16'h83E0
`define NVSR_SEQ_ADDR3 16'h7C1F
`define NVSR_SEQ_ADDR4 16'h703F
`define NVSR_SEQ_STORE 16'h8FC0
`define NVSR_SEQ_RECALL 16'h4C63
`define NVSR_SEQ_PLS_OFF 16'h8B45
`define NVSR_SEQ_PLS_ON 16'h4B46
`define NVSR_SEQ_LAST 3'h5
// reset values
`define NVSR_PLS_EN_RST 1'b1
// timing, in ns
`define NVSR_CLK_PERIOD_NS 20
`define NVSR_STORE_START_DELAY_NS 25000
`define NVSR_BUSY_HIGH_DRIVE_NS 500
`define NVSR_POST_BUSY_HOLDOFF_NS 5
`define NVSR_POWERUP_RECALL_NS 20000000
`define NVSR_STORE_CYCLE_NS 8000000
`define NVSR_RECALL_CYCLE_NS 200000
`define NVSR_ACCESS_NS 45
`endif

// ==== rtl/nvsr_pkg.sv ====
package nvsr_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ACCESS = 3'h1,
      ST_RECOVER = 3'h3,
      ST_NV_WAIT = 3'h2,
      ST_WAIT_HIGH = 3'h6,
      ST_HOLDOFF = 3'h7,
      ST_HW_PULL = 3'h5,
      ST_BOOT = 3'h4
   } nvsr_state_t;

   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_WRITE = 3'h1,
      CMD_SW_STORE = 3'h2,
      CMD_SW_RECALL = 3'h3,
      CMD_PLS_OFF = 3'h4,
      CMD_PLS_ON = 3'h5,
      CMD_HW_STORE = 3'h6
   } nvsr_cmd_t;
endpackage : nvsr_pkg

// ==== rtl/nvsr_sync.sv ====
`timescale 1ns/1ps
module nvsr_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // level in and out
   input wire logic i_async,
   output logic o_sync
);
   logic meta_q;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : nvsr_sync

// ==== test/nvsr_dev_model.sv ====
`timescale 1ns/1ps
`include "nvsr_map.svh"
module nvsr_dev_model #(
   parameter int START_CYC = 10,
   parameter int HHHD_CYC = 5,
   parameter int STORE_CYC = 100,
   parameter int RECALL_CYC = 50,
   parameter int PWRUP_CYC = 100,
   parameter int HOLD_CYC = 3
) (
   // clock and power
   input wire logic i_sys_clk,
   input wire logic i_pwr_rst,
   input wire logic i_supply_low,
   // memory pins
   input wire logic [18:0] i_addr,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq,
   // busy pin
   input wire logic i_busy_n,
   output logic o_pull,
   // observation
   output int o_stores,
   output int o_recalls,
   output logic o_pls_en
);
   localparam logic [15:0] SEQ_A [5] = '{`NVSR_SEQ_ADDR0, `NVSR_SEQ_ADDR1, `NVSR_SEQ_ADDR2,
      `NVSR_SEQ_ADDR3, `NVSR_SEQ_ADDR4};
   logic [15:0] mem [256];
   logic [15:0] nv [256];
   logic [15:0] dq_q;
   logic rd_q, wr_q, wr_ok, dirty, rec_req;
   logic [1:0] kind;
   logic [2:0] seq;
   int nv_cnt, hi_cnt, hold_cnt, req_cnt;
   wire rd = !i_ce_n && !i_oe_n && i_we_n;
   wire wr = !i_ce_n && !i_we_n;
   wire en = nv_cnt == 0 && hold_cnt == 0 && i_busy_n && !i_supply_low;
   wire [7:0] a = i_addr[7:0];

   function automatic logic hit(input logic [15:0] c);
      return i_addr[14:2] == c[14:2];
   endfunction : hit

   // sw recall keeps the pin alone, stores and power-up recall pull it
   assign o_pull = nv_cnt != 0 && kind != 2'h2;
   // released bus shows a toggling pattern, never the last value
   assign o_dq = (rd && en) ? mem[a] : ~dq_q;

   initial begin
      for (int i = 0; i < 256; i++) begin
         nv[i] = 16'h0000;
      end
   end

   always @(posedge i_sys_clk or posedge i_pwr_rst) begin
      if (i_pwr_rst) begin
         nv_cnt <= PWRUP_CYC;
         kind <= 2'h1;
         {rd_q, wr_q, wr_ok, dirty, rec_req} <= 5'h00;
         seq <= 3'h0;
         hi_cnt <= 0;
         hold_cnt <= 0;
         req_cnt <= 0;
         o_stores <= 0;
         o_recalls <= 0;
         o_pls_en <= 1'b1;
         dq_q <= 16'h0000;
      end else begin
         rd_q <= rd;
         wr_q <= wr;
         dq_q <= o_dq;
         if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
         if (hi_cnt != 0) hi_cnt <= hi_cnt - 1;
         req_cnt <= (i_busy_n || o_pull) ? 0 : req_cnt + 1;
         if (wr && !wr_q) begin
            seq <= 3'h0;
            wr_ok <= en;
         end
         if (wr && wr_ok && en) begin
            mem[a] <= i_dq;
            dirty <= 1'b1;
         end
         if (i_supply_low) begin
            rec_req <= 1'b1;
         end else if (rec_req) begin
            rec_req <= 1'b0;
            nv_cnt <= PWRUP_CYC;
            kind <= 2'h1;
         end else if (nv_cnt != 0) begin
            nv_cnt <= nv_cnt - 1;
            if (nv_cnt == 1) begin
               for (int i = 0; i < 256; i++) begin
                  if (kind == 2'h0) nv[i] <= mem[i];
                  else mem[i] <= nv[i];
               end
               dirty <= 1'b0;
               hold_cnt <= HOLD_CYC;
               hi_cnt <= (kind == 2'h2) ? 0 : HHHD_CYC;
               if (kind == 2'h0) o_stores <= o_stores + 1;
               if (kind == 2'h2) o_recalls <= o_recalls + 1;
            end
         end else if (req_cnt == START_CYC && dirty) begin
            nv_cnt <= STORE_CYC;
            kind <= 2'h0;
         end else if (rd && !rd_q && hold_cnt == 0) begin
            seq <= hit(`NVSR_SEQ_ADDR0) ? 3'h1 : 3'h0;
            if (seq < 3'h5 && hit(SEQ_A[seq])) seq <= seq + 3'h1;
            if (seq == 3'h5) begin
               if (hit(`NVSR_SEQ_STORE)) begin
                  nv_cnt <= STORE_CYC;
                  kind <= 2'h0;
               end
               if (hit(`NVSR_SEQ_RECALL)) begin
                  nv_cnt <= RECALL_CYC;
                  kind <= 2'h2;
               end
               if (hit(`NVSR_SEQ_PLS_OFF)) o_pls_en <= 1'b0;
               if (hit(`NVSR_SEQ_PLS_ON)) o_pls_en <= 1'b1;
            end
         end
      end
   end
endmodule : nvsr_dev_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic clk, rst, cmd_valid, supply_low;
   logic [2:0] cmd;
   logic [18:0] addr, m_addr;
   logic [15:0] wdata, rdata, dq_h, dq_d;
   logic cmd_ready, rsp_valid, dirty, pls_en, ce_n, oe_n, we_n, dq_oe, busy_o, busy_oe, dev_pull, dev_pls;
   logic ube_n, lbe_n;
   int stores, recalls, bad_count, cmp_count, low_cnt, s;
   // open-drain wire with pull-up
   wire busy_n = ~((busy_oe & ~busy_o) | dev_pull);

   nvsr_host #(.STORE_START_DELAY_NS(400), .POST_BUSY_HOLDOFF_NS(100), .POWERUP_RECALL_NS(2000),
      .STORE_CYCLE_NS(2000), .RECALL_CYCLE_NS(1000), .ACCESS_NS(45)) dut_u (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_addr(addr),
      .i_wdata(wdata), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rdata(rdata),
      .o_dirty(dirty), .o_power_loss_store_en(pls_en), .i_supply_low(supply_low), .o_addr(m_addr),
      .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_upper_byte_enable_n(ube_n), .o_lower_byte_enable_n(lbe_n),
      .i_dq(dq_d), .o_dq(dq_h), .o_dq_oe(dq_oe), .i_store_busy_request_n(busy_n),
      .o_store_busy_request_n(busy_o), .o_store_busy_request_n_oe(busy_oe));

   nvsr_dev_model dev_u (.i_sys_clk(clk), .i_pwr_rst(rst), .i_supply_low(supply_low), .i_addr(m_addr),
      .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq_h), .o_dq(dq_d), .i_busy_n(busy_n),
      .o_pull(dev_pull), .o_stores(stores), .o_recalls(recalls), .o_pls_en(dev_pls));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      if (busy_n === 1'b0) low_cnt <= low_cnt + 1;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up

   task automatic do_cmd(input logic [2:0] c, input logic [18:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd = c;
      addr = a;
      wdata = d;
      while (cmd_ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         $display("MISMATCH cmd_done expected 1 seen 0");
         wrap_up();
      end
   endtask : do_cmd

   task automatic t_boot();
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      chk("ready", cmd_ready, 1);
      chk("pwrup_low", low_cnt >= 100, 1);
      chk("pls_en", pls_en, 1);
      chk("byte_en_n", {ube_n, lbe_n}, 0);
      do_cmd(3'h0, 19'h00012, 16'h0000);
      chk("rdata", rdata, 16'h0000);
      $display("test boot done");
   endtask : t_boot

   task automatic t_rw_store();
      do_cmd(3'h1, 19'h00012, 16'hA55A);
      do_cmd(3'h0, 19'h00012, 16'h0000);
      chk("rdata", rdata, 16'hA55A);
      chk("dirty", dirty, 1);
      s = stores;
      low_cnt = 0;
      do_cmd(3'h2, 19'h00000, 16'h0000);
      chk("stores", stores, s + 1);
      chk("store_low", low_cnt >= 100, 1);
      chk("dirty", dirty, 0);
      do_cmd(3'h2, 19'h00000, 16'h0000);
      chk("stores", stores, s + 2);
      $display("test write and sw store done");
   endtask : t_rw_store

   task automatic t_recall_pls();
      do_cmd(3'h1, 19'h00012, 16'h1234);
      s = recalls;
      do_cmd(3'h3, 19'h00000, 16'h0000);
      chk("recalls", recalls, s + 1);
      do_cmd(3'h0, 19'h00012, 16'h0000);
      chk("rdata", rdata, 16'hA55A);
      s = stores;
      do_cmd(3'h4, 19'h00000, 16'h0000);
      chk("dev_pls", dev_pls, 0);
      chk("pls_en", pls_en, 0);
      chk("stores", stores, s + 1);
      do_cmd(3'h5, 19'h00000, 16'h0000);
      chk("dev_pls", dev_pls, 1);
      chk("pls_en", pls_en, 1);
      $display("test recall and power-loss setting done");
   endtask : t_recall_pls

   task automatic t_hw();
      do_cmd(3'h1, 19'h00012, 16'h0F0F);
      s = stores;
      do_cmd(3'h6, 19'h00000, 16'h0000);
      chk("stores", stores, s + 1);
      do_cmd(3'h6, 19'h00000, 16'h0000);
      chk("stores", stores, s + 1);
      $display("test hw store done");
   endtask : t_hw

   task automatic t_low();
      int n;
      n = 0;
      do_cmd(3'h1, 19'h00012, 16'hBEEF);
      supply_low = 1'b1;
      repeat (5) @(negedge clk);
      chk("ready", cmd_ready, 0);
      supply_low = 1'b0;
      low_cnt = 0;
      repeat (3) @(negedge clk);
      while (busy_n !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      chk("busy_back", busy_n, 1);
      chk("recall_low", low_cnt >= 100, 1);
      repeat (10) @(negedge clk);
      do_cmd(3'h0, 19'h00012, 16'h0000);
      chk("rdata", rdata, 16'h0F0F);
      $display("test low supply done");
   endtask : t_low

   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = 3'h0;
      addr = 19'h00000;
      wdata = 16'h0000;
      supply_low = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      low_cnt = 0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      t_boot();
      t_rw_store();
      t_recall_pls();
      t_hw();
      t_low();
      wrap_up();
   end
endmodule : tb
